// [design/sehf_defines.svh]
/*
  Shared constants of the serial peripheral with enable handshake:
  widths, limits, reset values and timing counts.
  Assumes inclusion by bare name from the package and the top module.
*/
// Contract
// - master drives clock and input line only; code also drives select in five-pin mode
// - slave handshake follows buffer and tristate choice
// - slave drops handshake when transfer completes
// - slave raises handshake on new transmit data
// - master waits for slave handshake before starting
// - handshake pin push-pull or high-impedance selectable
// - five-pin mode uses handshake and select together
// - slave output driver follows select asynchronously
// - slave handshake waits for select asserted
// - tristate choice: undriven, low when ready
// - push-pull choice: high, low when ready
// - push-pull: driven high on deselect
// - shared handshake line needs tristate choice
// - early deselect tristates output and handshake; with push-pull choice code drives handshake high instead
// - clock edge after early deselect flags length error
// - four format sets: length, order, polarity, phase
// - character length two to sixteen bits
// - second data register write latches format select
// - format stays until another is selected
// - received data right-aligned, zero filled
// - order zero msb first, one lsb first
// - polarity and phase pick change and sample edges
// - both role bits one master, zero slave
`ifndef SEHF_DEFINES_SVH
`define SEHF_DEFINES_SVH
`define SEHF_DATA_W     16
`define SEHF_LEN_MIN    5'h02
`define SEHF_LEN_MAX    5'h10
`define SEHF_FIFO_DEPTH 16
`define SEHF_FMT_RST    2'h0
`define SEHF_DIV_RST    8'h00
`define SEHF_PIN_RST    5'h0c
`define SEHF_CLK_NS     10
`define SEHF_GAP_NS     120
`define SEHF_GAP_CYC    ((`SEHF_GAP_NS + `SEHF_CLK_NS - 1) / `SEHF_CLK_NS)
`endif

// [design/sehf_pkg.sv]
/*
  Types of the serial peripheral: format set, queued transmit word
  and master sequencer states.
  Assumes the defines header is on the include path.
*/
`include "sehf_defines.svh"
package sehf_pkg;
  typedef struct packed {
    logic [4:0] char_length;
    logic       bit_order;
    logic       polarity;
    logic       phase;
  } sehf_fmt_type;

  typedef struct packed {
    logic                     fmt_write;
    logic [1:0]               format_select;
    logic [`SEHF_DATA_W-1:0]  data;
  } sehf_txw_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SELECT = 2'b01,
    ST_SHIFT  = 2'b10,
    ST_GAP    = 2'b11
  } sehf_mst_type;
endpackage : sehf_pkg

// [design/sehf_fifo_if.sv]
/*
  Valid/ready word link between the transmit queue and its user.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
interface sehf_fifo_if #(parameter int W = 19);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface : sehf_fifo_if

// [design/sehf_fifo.sv]
/*
  Transmit word queue with a registered head stage.
  Assumes DEPTH is a power of two and one clock domain.
*/
`timescale 1ns/1ns
module sehf_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input wire logic   i_clk_sys,
  input wire logic   i_rst_b,
  sehf_fifo_if.fifo  io_fifo
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  cnt_q;
  logic [AW:0]  cnt_d;
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic         rdy_q;
  logic         out_v_q;
  logic [W-1:0] out_q;
  logic         push;
  logic         load;

  assign push = io_fifo.wr_valid & rdy_q;
  // head refills when drained; a stalled reader lets the queue fill
  assign load = (cnt_q != '0) & (~out_v_q | io_fifo.rd_ready);
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
  assign io_fifo.wr_ready = rdy_q;
  assign io_fifo.rd_valid = out_v_q;
  assign io_fifo.rd_data  = out_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
    begin
      mem_q[wp_q] <= io_fifo.wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= '0;
      wp_q  <= '0;
      rp_q  <= '0;
      rdy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rdy_q <= (32'(cnt_d) < DEPTH);
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (load)
      begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      out_v_q <= 1'b0;
      out_q   <= '0;
    end
    else if (load)
    begin
      out_v_q <= 1'b1;
      out_q   <= mem_q[rp_q];
    end
    else if (io_fifo.rd_ready)
    begin
      out_v_q <= 1'b0;
    end
  end

  a_fifo_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (32'(cnt_q) == DEPTH) |-> !rdy_q)
    else $error("queue full but still ready");
endmodule : sehf_fifo

// [design/sehf_spi_top.sv]
/*
  Serial peripheral core for the enable and five-pin options:
  master sequencer, slave shifter, ready handshake, format sets.
  Assumes format and mode inputs are static during a character and
  the link pins are resolved from the enables outside.
*/
`timescale 1ns/1ns
`include "sehf_defines.svh"
module sehf_spi_top
  import sehf_pkg::*;
#(
  parameter int FIFO_DEPTH = `SEHF_FIFO_DEPTH
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_b,
  input  wire logic               i_clock_source_sel,
  input  wire logic               i_master_sel,
  input  wire logic               i_handshake_func,
  input  wire logic               i_select_func,
  input  wire logic               i_handshake_tristate_sel,
  input  wire sehf_fmt_type [3:0] i_format_set,
  input  wire logic [7:0]         i_prescale,
  input  wire logic               i_tx_valid,
  input  wire logic [15:0]        i_tx_data,
  input  wire logic               i_tx_fmt_write,
  input  wire logic [1:0]         i_tx_format_select,
  output logic                    o_tx_ready,
  output logic                    o_rx_valid,
  output logic [15:0]             o_rx_data,
  input  wire logic               i_length_error_clr,
  output logic                    o_length_error_flag,
  input  wire logic               i_serial_clock_pin,
  output logic                    o_serial_clock_pin,
  output logic                    o_serial_clock_oe,
  input  wire logic               i_slave_in_line,
  output logic                    o_slave_in_line,
  output logic                    o_slave_in_oe,
  input  wire logic               i_slave_out_line,
  output logic                    o_slave_out_line,
  output logic                    o_slave_out_oe,
  input  wire logic               i_slave_select_pin,
  output logic                    o_slave_select_pin,
  output logic                    o_slave_select_oe,
  input  wire logic               i_ready_handshake_pin,
  output logic                    o_ready_handshake_pin,
  output logic                    o_ready_handshake_oe
);
  function automatic logic [4:0] eff_len(input logic [4:0] l);
    if (l < `SEHF_LEN_MIN)
      eff_len = `SEHF_LEN_MIN;
    else if (l > `SEHF_LEN_MAX)
      eff_len = `SEHF_LEN_MAX;
    else
      eff_len = l;
  endfunction : eff_len

  // right-aligned word to first-bit-at-top shift image
  function automatic logic [15:0] prep(input logic [15:0] d,
                                       input logic [4:0]  l,
                                       input logic        lsb);
    logic [15:0] r;
    for (int i = 0; i < 16; i++)
      r[i] = d[15-i];
    prep = lsb ? r : (d << (`SEHF_LEN_MAX - l));
  endfunction : prep

  sehf_fifo_if #(.W($bits(sehf_txw_type))) tx_if ();

  sehf_fifo #(
    .W     ($bits(sehf_txw_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .io_fifo   (tx_if.fifo)
  );

  logic [4:0]   pin_s1_q;
  logic [4:0]   pin_s2_q;
  logic         sclk_s3_q;
  logic [2:0]   arm_q;
  logic         mst_q;
  logic         slv_q;
  logic         ss_oe_q;
  logic [1:0]   cur_fmt_q;
  logic [7:0]   div_q;
  sehf_mst_type st_q;
  logic [5:0]   tog_q;
  logic [3:0]   gap_q;
  logic         sclk_q;
  logic         ss_q;
  logic [4:0]   bit_cnt_q;
  logic [15:0]  tx_sh_q;
  logic [15:0]  rx_sh_q;
  logic         out_q;
  logic         tx_loaded_q;
  logic         early_q;
  logic         err_q;
  logic         rx_v_q;
  logic [15:0]  rx_d_q;
  logic         hs_oe_q;
  logic         hs_pin_q;

  sehf_txw_type head;
  sehf_fmt_type fmt;
  sehf_fmt_type nfmt;
  logic [1:0]   nf_idx;
  logic [4:0]   len;
  logic [15:0]  pw;
  logic sclk_s, ss_s, ena_s, simo_s, somi_s, rise, fall;
  logic take, pop, tick, mev, mdone, s_act, lead, trail, samp, outp;
  logic din, rx_done, desel, err_ev, hs_rdy;
  logic [15:0]  rx_nx;

  assign tx_if.wr_valid = i_tx_valid;
  assign tx_if.wr_data  = {i_tx_fmt_write, i_tx_format_select, i_tx_data};
  assign o_tx_ready     = tx_if.wr_ready;
  assign head           = sehf_txw_type'(tx_if.rd_data);

  assign {sclk_s, ss_s, ena_s, simo_s, somi_s} = pin_s2_q;
  // idle clock level follows polarity, so compare only real samples
  assign rise = arm_q[2] & sclk_s & ~sclk_s3_q;
  assign fall = arm_q[2] & ~sclk_s & sclk_s3_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_s1_q  <= `SEHF_PIN_RST;
      pin_s2_q  <= `SEHF_PIN_RST;
      sclk_s3_q <= 1'b0;
      arm_q     <= 3'h0;
    end
    else
    begin
      pin_s1_q  <= {i_serial_clock_pin, i_slave_select_pin,
                    i_ready_handshake_pin, i_slave_in_line,
                    i_slave_out_line};
      pin_s2_q  <= pin_s1_q;
      sclk_s3_q <= pin_s2_q[4];
      arm_q     <= {arm_q[1:0], 1'b1};
    end
  end

  // mixed role bits leave every driver off
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mst_q   <= 1'b0;
      slv_q   <= 1'b0;
      ss_oe_q <= 1'b0;
    end
    else
    begin
      mst_q   <= i_clock_source_sel & i_master_sel;
      slv_q   <= ~(i_clock_source_sel | i_master_sel);
      ss_oe_q <= i_clock_source_sel & i_master_sel & i_select_func;
    end
  end

  assign fmt    = i_format_set[cur_fmt_q];
  assign len    = eff_len(fmt.char_length);
  assign nf_idx = head.fmt_write ? head.format_select : cur_fmt_q;
  assign nfmt   = i_format_set[nf_idx];
  assign pw     = prep(head.data, eff_len(nfmt.char_length),
                       nfmt.bit_order);

  // slave never loads on an edge cycle so no edge is lost
  assign take = mst_q ? (st_q == ST_IDLE)
                      : (slv_q & ~tx_loaded_q & (bit_cnt_q == 5'h00) &
                         ~rise & ~fall);
  assign pop  = tx_if.rd_valid & take;
  assign tx_if.rd_ready = take;

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cur_fmt_q <= `SEHF_FMT_RST;
    else if (pop && head.fmt_write)
      cur_fmt_q <= head.format_select;
  end

  assign tick = (div_q == 8'h00);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div_q <= `SEHF_DIV_RST;
    else
      div_q <= tick ? i_prescale : (div_q - 8'h01);
  end

  assign mev   = mst_q & (st_q == ST_SHIFT) & tick;
  assign mdone = mev & (tog_q == ({1'b0, len} << 1) - 6'h01);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_q   <= ST_IDLE;
      tog_q  <= 6'h00;
      gap_q  <= 4'h0;
      sclk_q <= 1'b0;
      ss_q   <= 1'b1;
    end
    else if (!mst_q)
    begin
      st_q <= ST_IDLE;
      ss_q <= 1'b1;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          sclk_q <= fmt.polarity;
          ss_q   <= 1'b1;
          if (pop)
          begin
            st_q  <= ST_SELECT;
            ss_q  <= 1'b0;
            tog_q <= 6'h00;
          end
        end
        ST_SELECT:
        begin
          sclk_q <= fmt.polarity;
          if (!i_handshake_func || !ena_s)
            st_q <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (mev)
          begin
            sclk_q <= ~sclk_q;
            tog_q  <= tog_q + 6'h01;
          end
          if (mdone)
          begin
            st_q  <= ST_GAP;
            ss_q  <= 1'b1;
            gap_q <= 4'(`SEHF_GAP_CYC);
          end
        end
        ST_GAP:
        begin
          // covers handshake sync lag so a stale ready is not seen
          if (gap_q == 4'h0)
            st_q <= ST_IDLE;
          else
            gap_q <= gap_q - 4'h1;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  assign s_act = slv_q & (~i_select_func | ~ss_s);
  assign lead  = (mev & (sclk_q == fmt.polarity)) |
                 (s_act & (fmt.polarity ? fall : rise));
  assign trail = (mev & (sclk_q != fmt.polarity)) |
                 (s_act & (fmt.polarity ? rise : fall));
  assign samp  = fmt.phase ? lead : trail;
  assign outp  = fmt.phase ? trail : lead;
  assign din   = mst_q ? somi_s : simo_s;
  assign rx_nx = fmt.bit_order ? {din, rx_sh_q[15:1]}
                               : {rx_sh_q[14:0], din};
  assign rx_done = samp & (bit_cnt_q == len - 5'h01);
  assign desel   = slv_q & i_select_func & ss_s;
  assign err_ev  = early_q & desel & (rise | fall);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_sh_q   <= 16'h0000;
      rx_sh_q   <= 16'h0000;
      bit_cnt_q <= 5'h00;
      out_q     <= 1'b0;
    end
    else if (pop)
    begin
      bit_cnt_q <= 5'h00;
      rx_sh_q   <= 16'h0000;
      tx_sh_q   <= nfmt.phase ? (pw << 1) : pw;
      if (nfmt.phase)
        out_q <= pw[15];
    end
    else if (err_ev)
    begin
      bit_cnt_q <= 5'h00;
      rx_sh_q   <= 16'h0000;
    end
    else
    begin
      if (outp)
      begin
        out_q   <= tx_sh_q[15];
        tx_sh_q <= tx_sh_q << 1;
      end
      if (samp && rx_done)
      begin
        bit_cnt_q <= 5'h00;
        rx_sh_q   <= 16'h0000;
      end
      else if (samp)
      begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
        rx_sh_q   <= rx_nx;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_v_q <= 1'b0;
      rx_d_q <= 16'h0000;
    end
    else
    begin
      rx_v_q <= rx_done;
      if (rx_done)
        rx_d_q <= fmt.bit_order ? (rx_nx >> (`SEHF_LEN_MAX - len))
                                : rx_nx;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_loaded_q <= 1'b0;
      early_q     <= 1'b0;
      err_q       <= 1'b0;
    end
    else
    begin
      if (pop && slv_q)
        tx_loaded_q <= 1'b1;
      else if (rx_done && slv_q)
        tx_loaded_q <= 1'b0;
      if (err_ev || rx_done || pop)
        early_q <= 1'b0;
      else if (desel && bit_cnt_q != 5'h00)
        early_q <= 1'b1;
      // set wins over a clear in the same cycle
      if (err_ev)
        err_q <= 1'b1;
      else if (i_length_error_clr)
        err_q <= 1'b0;
    end
  end

  // deselect drops ready, which also covers early deselect
  assign hs_rdy = tx_loaded_q & (~i_select_func | ~ss_s);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hs_oe_q  <= 1'b0;
      hs_pin_q <= 1'b1;
    end
    else if (!slv_q || !i_handshake_func)
    begin
      hs_oe_q  <= 1'b0;
      hs_pin_q <= 1'b1;
    end
    else if (i_handshake_tristate_sel)
    begin
      // shared line: only the ready slave pulls low
      hs_oe_q  <= hs_rdy;
      hs_pin_q <= 1'b0;
    end
    else
    begin
      hs_oe_q  <= 1'b1;
      hs_pin_q <= ~hs_rdy;
    end
  end

  assign o_serial_clock_pin    = sclk_q;
  assign o_serial_clock_oe     = mst_q;
  assign o_slave_in_line       = out_q;
  assign o_slave_in_oe         = mst_q;
  assign o_slave_out_line      = out_q;
  // raw pin on purpose: driver release must not wait for the clock
  assign o_slave_out_oe        = slv_q &
                                 (~i_select_func | ~i_slave_select_pin);
  assign o_slave_select_pin    = ss_q;
  assign o_slave_select_oe     = ss_oe_q;
  assign o_ready_handshake_pin = hs_pin_q;
  assign o_ready_handshake_oe  = hs_oe_q;
  assign o_rx_valid            = rx_v_q;
  assign o_rx_data             = rx_d_q;
  assign o_length_error_flag   = err_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_slv_load;
    slv_q && pop && !i_select_func && i_handshake_func;
  endsequence
  sequence s_hiz_idle;
    slv_q && i_handshake_func && i_handshake_tristate_sel &&
      !tx_loaded_q ##1 slv_q && i_handshake_tristate_sel;
  endsequence
  sequence s_early_desel;
    early_q && desel && (rise || fall);
  endsequence

  a_master_pins_hiz: assert property (
    mst_q && $past(mst_q) |->
      !o_slave_out_oe && !o_ready_handshake_oe && o_serial_clock_oe)
    else $error("master drives output line or handshake");
  a_hs_drop_done: assert property (
    slv_q && rx_done |-> ##2 !(o_ready_handshake_oe &&
                               !o_ready_handshake_pin))
    else $error("handshake still ready after transfer");
  a_hs_raise_load: assert property (
    s_slv_load |-> ##2 (o_ready_handshake_oe && !o_ready_handshake_pin))
    else $error("handshake not raised after load");
  a_master_hold_off: assert property (
    mst_q && st_q == ST_SELECT && i_handshake_func && ena_s
      |=> st_q != ST_SHIFT)
    else $error("master started without slave ready");
  a_hiz_default: assert property (
    s_hiz_idle |-> !o_ready_handshake_oe)
    else $error("handshake driven while idle in tristate choice");
  a_pp_deselect: assert property (
    slv_q && i_handshake_func && !i_handshake_tristate_sel && desel
      |=> o_ready_handshake_oe && o_ready_handshake_pin)
    else $error("push-pull handshake not high on deselect");
  a_len_error: assert property (
    s_early_desel |=> o_length_error_flag && bit_cnt_q == 5'h00)
    else $error("length error not flagged");
  a_fmt_latch: assert property (
    pop && head.fmt_write |=> cur_fmt_q == $past(head.format_select))
    else $error("format select not latched");
  a_fmt_hold: assert property (
    !pop |=> $stable(cur_fmt_q))
    else $error("format changed without a select write");
  a_rx_zero_fill: assert property (
    o_rx_valid |-> (o_rx_data >> $past(len)) == 16'h0000)
    else $error("received word not zero filled");
  a_bit_count: assert property (
    slv_q |-> bit_cnt_q < len)
    else $error("bit count passed character length");
endmodule : sehf_spi_top

// [dv/sehf_link_master.sv]
/*
  Behavioural link master that faces the block in its slave role.
  Assumes the bench resolves the handshake and data lines and calls xfer.
*/
`timescale 1ns/1ns
module sehf_link_master
  import sehf_pkg::*;
(
  input  wire logic i_ready_b,
  input  wire logic i_data_in,
  output logic      o_sclk,
  output logic      o_data_out,
  output logic      o_select_b
);
  int timeouts = 0;

  initial
  begin
    o_sclk     = 1'b0;
    o_data_out = 1'b0;
    o_select_b = 1'b1;
  end

  // cut < 0: select then deselect, no clocks; cut > 0: stray edge after
  task automatic xfer(input logic [15:0] d, input sehf_fmt_type f,
                      input int cut, output logic [15:0] r);
    int n;
    int b;
    int w;
    r = 16'h0000;
    n = (cut < 0) ? 0 : (cut > 0) ? cut : int'(f.char_length);
    o_sclk = f.polarity;
    // odd offset keeps every pin change off the sampling clock edge
    #202;
    o_select_b = 1'b0;
    w = 0;
    // hold off until the slave reports ready
    while (i_ready_b !== 1'b0 && w < 400)
    begin
      #10;
      w++;
    end
    if (i_ready_b !== 1'b0)
      timeouts++;
    for (int i = 0; i < n; i++)
    begin
      b = f.bit_order ? i : int'(f.char_length) - 1 - i;
      if (f.phase)
        o_data_out = d[b];
      #62;
      o_sclk = ~f.polarity;
      if (f.phase)
        r[b] = i_data_in;
      else
        o_data_out = d[b];
      #63;
      o_sclk = f.polarity;
      if (!f.phase)
        r[b] = i_data_in;
    end
    #62;
    o_select_b = 1'b1;
    // released line must not keep showing the last bit
    o_data_out = ~o_data_out;
    if (cut > 0)
    begin
      #62;
      o_sclk = ~f.polarity;
      #63;
      o_sclk = f.polarity;
    end
    #200;
  endtask : xfer
endmodule : sehf_link_master

// [dv/sehf_spi_top_test.sv]
/*
  Self-checking bench: slave formats and handshake, early deselect,
  master hold-off with the data lines looped back.
  Assumes the design package and the link master model are compiled.
*/
`timescale 1ns/1ns
module sehf_spi_top_test;
  import sehf_pkg::*;
  localparam logic [15:0] TD [4] = '{16'hA5C3, 16'hFFF6, 16'h0002, 16'h0EC9};
  localparam logic [15:0] PD [4] = '{16'h3C5A, 16'h0009, 16'hFFFD, 16'h0A3A};
  logic               clk = 1'b0, rst_b = 1'b0, mst = 1'b0, hz = 1'b0;
  logic               sel_f = 1'b1;
  logic               rdy_b = 1'b1, clr = 1'b0, tx_v = 1'b0, tx_f = 1'b0;
  logic [15:0]        tx_d = 16'h0000, rx_got = 16'h0000, junk;
  logic [1:0]         tx_s = 2'h0;
  sehf_fmt_type [3:0] fmts;
  logic               tx_rdy, rx_v, err, ck_o, ck_oe, mo, mo_oe, so, so_oe;
  logic               ss_o, ss_oe, hs_o, hs_oe, p_ck, p_mo, p_ss;
  logic [15:0]        rx_d;
  int                 rx_n = 0, n0, bad_count = 0, samples_checked = 0;
  // open-drain handshake has a pull-up
  wire                hs_w = hs_oe ? hs_o : 1'b1;
  wire                so_w = so_oe ? so : ~so;

  always #5 clk = ~clk;

  always @(posedge clk)
    if (rx_v === 1'b1)
    begin
      rx_got <= rx_d;
      rx_n   <= rx_n + 1;
    end

  sehf_spi_top dut (
    .i_clk_sys(clk), .i_rst_b(rst_b),
    .i_clock_source_sel(mst), .i_master_sel(mst),
    .i_handshake_func(1'b1), .i_select_func(sel_f),
    .i_handshake_tristate_sel(hz), .i_format_set(fmts),
    .i_prescale(8'h03), .i_tx_valid(tx_v), .i_tx_data(tx_d),
    .i_tx_fmt_write(tx_f), .i_tx_format_select(tx_s),
    .o_tx_ready(tx_rdy), .o_rx_valid(rx_v), .o_rx_data(rx_d),
    .i_length_error_clr(clr), .o_length_error_flag(err),
    .i_serial_clock_pin(p_ck), .o_serial_clock_pin(ck_o),
    .o_serial_clock_oe(ck_oe), .i_slave_in_line(p_mo),
    .o_slave_in_line(mo), .o_slave_in_oe(mo_oe),
    .i_slave_out_line(mst ? mo : so_w), .o_slave_out_line(so),
    .o_slave_out_oe(so_oe), .i_slave_select_pin(mst ? ss_o : p_ss),
    .o_slave_select_pin(ss_o), .o_slave_select_oe(ss_oe),
    .i_ready_handshake_pin(mst ? rdy_b : hs_w),
    .o_ready_handshake_pin(hs_o), .o_ready_handshake_oe(hs_oe)
  );

  sehf_link_master part (
    .i_ready_b(hs_w), .i_data_in(so_w),
    .o_sclk(p_ck), .o_data_out(p_mo), .o_select_b(p_ss)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic push(input logic [15:0] d, input logic fw,
                      input logic [1:0] s);
    @(posedge clk);
    tx_v <= 1'b1;
    tx_d <= d;
    tx_f <= fw;
    tx_s <= s;
    do @(posedge clk); while (tx_rdy !== 1'b1);
    tx_v <= 1'b0;
  endtask : push

  task automatic sxfer(input logic [15:0] d, input logic [15:0] pd,
                       input int f);
    logic [15:0] r;
    logic [15:0] m;
    m = 16'hFFFF >> (16 - int'(fmts[f].char_length));
    n0 = rx_n;
    part.xfer(pd, fmts[f], 0, r);
    check(r, d & m);
    check(rx_got, pd & m);
    check(16'(rx_n - n0), 16'h0001);
    check(16'({hs_oe, hs_o}), hz ? 16'h0000 : 16'h0003);
  endtask : sxfer

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial
  begin
    fmts[0] = '{5'h10, 1'b0, 1'b0, 1'b0};
    fmts[1] = '{5'h05, 1'b1, 1'b0, 1'b1};
    fmts[2] = '{5'h02, 1'b0, 1'b1, 1'b0};
    fmts[3] = '{5'h0c, 1'b1, 1'b1, 1'b1};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check(16'({hs_oe, hs_o}), 16'h0003);
    push(TD[0], 1'b1, 2'h0);
    repeat (10) @(posedge clk);
    check(16'({hs_oe, hs_o}), 16'h0003);
    part.xfer(16'h0000, fmts[0], -1, junk);
    check(16'({hs_oe, hs_o}), 16'h0003);
    for (int f = 0; f < 4; f++)
    begin
      if (f > 0)
        push(TD[f], 1'b1, 2'(f));
      sxfer(TD[f], PD[f], f);
    end
    push(16'h0123, 1'b0, 2'h0);
    sxfer(16'h0123, 16'h0456, 3);
    @(posedge clk);
    sel_f <= 1'b0;
    push(16'h0ABC, 1'b0, 2'h0);
    repeat (5) @(posedge clk);
    check(16'({hs_oe, hs_o}), 16'h0002);
    sxfer(16'h0ABC, 16'h0765, 3);
    $display("test push-pull slave formats done");
    @(posedge clk);
    hz    <= 1'b1;
    sel_f <= 1'b1;
    repeat (3) @(posedge clk);
    check(16'(hs_oe), 16'h0000);
    push(16'h00F0, 1'b1, 2'h0);
    repeat (10) @(posedge clk);
    check(16'(hs_oe), 16'h0000);
    sxfer(16'h00F0, 16'h1357, 0);
    push(16'h1234, 1'b1, 2'h0);
    part.xfer(16'h0000, fmts[0], 5, junk);
    repeat (5) @(posedge clk);
    check(16'({so_oe, hs_oe, err}), 16'h0001);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    check(16'(err), 16'h0000);
    $display("test tristate and early deselect done");
    mst <= 1'b1;
    hz  <= 1'b0;
    repeat (3) @(posedge clk);
    n0 = rx_n;
    push(16'hC35A, 1'b1, 2'h0);
    repeat (40) @(posedge clk);
    check(16'({ck_oe, mo_oe, so_oe, hs_oe, ss_o}), 16'h0018);
    check(16'(rx_n - n0), 16'h0000);
    rdy_b <= 1'b0;
    for (int i = 0; i < 400 && rx_n == n0; i++)
      @(posedge clk);
    check(rx_got, 16'hC35A);
    check(16'(part.timeouts), 16'h0000);
    $display("test master hold-off done");
    print_verdict();
  end
endmodule : sehf_spi_top_test
